// file: include/pdc_consts.svh
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// Clock rate in kHz; deglitch figures in ns
`define PDC_CLK_KHZ          250000
`define PDC_ERR_DEGLITCH_NS  15000
`define PDC_WDD_DEGLITCH_NS  30000
`define PDC_EN_DEGLITCH_NS   8000
`define PDC_ADR_DEGLITCH_NS  8000
`define PDC_ERR_CYC          ((`PDC_ERR_DEGLITCH_NS * (`PDC_CLK_KHZ / 1000) + 999) / 1000)
`define PDC_WDD_CYC          ((`PDC_WDD_DEGLITCH_NS * (`PDC_CLK_KHZ / 1000) + 999) / 1000)
`define PDC_EN_CYC           ((`PDC_EN_DEGLITCH_NS * (`PDC_CLK_KHZ / 1000) + 999) / 1000)
`define PDC_ADR_CYC          ((`PDC_ADR_DEGLITCH_NS * (`PDC_CLK_KHZ / 1000) + 999) / 1000)
// Monitor filter-select codes 0..3 map to these deglitch times in ns
`define PDC_MON_SEL0_NS      4000
`define PDC_MON_SEL1_NS      8000
`define PDC_MON_SEL2_NS      16000
`define PDC_MON_SEL3_NS      32000
`define PDC_CNT_W            16
// Reset values of filtered levels and default drive settings
`define PDC_ERR_RESET        1'b1
`define PDC_LEVEL_RESET      1'b0
`define PDC_DRV_OPEN_DRAIN   1'b1
`define PDC_DRV_ACT_LOW      1'b1

`endif

// file: include/pdc_pkg.sv
package pdc_pkg;

    typedef struct packed {
        logic open_drain;
        logic active_low;
        logic pullup_enable;
    } pdc_drive_cfg_type;

    typedef struct packed {
        logic out;
        logic oe;
        logic pullup_on;
    } pdc_pin_drive_type;

    typedef enum logic [2:0] {
        PDC_WAIT_SUPPLY = 3'b001,
        PDC_WAIT_OTP    = 3'b010,
        PDC_RUN         = 3'b100
    } pdc_state_type;

endpackage

// file: rtl/pdc_deglitch.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"

module pdc_deglitch
    import pdc_pkg::*;
#(
    parameter logic [`PDC_CNT_W-1:0] RESET_LEVEL = `PDC_CNT_W'(`PDC_LEVEL_RESET)
)
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  clock_enable,
    input  wire logic                  enable,
    input  wire logic                  sample,
    input  wire logic [`PDC_CNT_W-1:0] interval,
    output logic                       level
);

    logic [`PDC_CNT_W-1:0] count;

    // Level passes after interval stable samples; a reversal restarts
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
            level <= RESET_LEVEL[0];
        end
        else if (clock_enable)
        begin
            if (!enable || sample == level)
            begin
                count <= '0;
            end
            else if (count + 1'b1 >= interval)
            begin
                count <= '0;
                level <= sample;
            end
            else
            begin
                count <= count + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/pdc_pin_conditioning.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"

// Function
// - Error input pulled up, 15 us deglitch
// - Watchdog-disable accepted after 30 us stable
// - Enable pulled low, 8 us deglitch
// - Address-select pin filtered 8 us
// - Monitor deglitch from own select fields
// - Enable works whenever supply valid
// - Other buffers off until settings loaded
// - Reset output mode, polarity, conditional pull-up
// - Interrupt output mode, polarity, independent
// - Shared error pin may disable watchdog
// - Multi-function pin: address sense or output
module pdc_pin_conditioning
    import pdc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              clock_enable,
    input  wire logic              analog_supply_rail_valid,
    input  wire logic              otp_loaded,
    input  wire logic              error_pin_alt_function,
    input  wire logic              multi_pin_is_input,
    input  wire logic [1:0]        monitor_one_filter_select,
    input  wire logic [1:0]        monitor_two_filter_select,
    input  wire pdc_drive_cfg_type reset_cfg,
    input  wire pdc_drive_cfg_type interrupt_cfg,
    input  wire logic              reset_request,
    input  wire logic              interrupt_request,
    input  wire logic              general_output_value,
    input  wire logic              mcu_error_input,
    input  wire logic              enable_input,
    input  wire logic              multi_pin_in,
    input  wire logic              voltage_monitor_one_input,
    input  wire logic              voltage_monitor_two_input,
    output logic                   error_pin_pullup_on,
    output logic                   enable_pulldown_on,
    output logic                   mcu_error_level,
    output logic                   watchdog_disable_input,
    output logic                   enable_level,
    output logic                   address_select_level,
    output logic                   monitor_one_level,
    output logic                   monitor_two_level,
    output logic                   buffers_enabled,
    output pdc_pin_drive_type      reset_output_pin,
    output pdc_pin_drive_type      interrupt_output_pin
);

    localparam int NUM_IN = 6;
    localparam logic [`PDC_CNT_W-1:0] ERR_CYC = `PDC_CNT_W'(`PDC_ERR_CYC);
    localparam logic [`PDC_CNT_W-1:0] WDD_CYC = `PDC_CNT_W'(`PDC_WDD_CYC);
    localparam logic [`PDC_CNT_W-1:0] EN_CYC  = `PDC_CNT_W'(`PDC_EN_CYC);
    localparam logic [`PDC_CNT_W-1:0] ADR_CYC = `PDC_CNT_W'(`PDC_ADR_CYC);
    // Pins idle open-drain active-low until settings arrive
    localparam pdc_drive_cfg_type DEFAULT_CFG = '{open_drain:    `PDC_DRV_OPEN_DRAIN,
                                                  active_low:    `PDC_DRV_ACT_LOW,
                                                  pullup_enable: 1'b1};

    pdc_state_type              state;
    logic [NUM_IN-1:0]          sync_a;
    logic [NUM_IN-1:0]          sync_b;
    logic [NUM_IN-1:0]          filt;
    logic [NUM_IN-1:0]          filt_en;
    logic [`PDC_CNT_W-1:0]      interval [NUM_IN];
    logic [NUM_IN-1:0]          raw;
    logic                       supply_a;
    logic                       supply_b;

    function automatic logic [`PDC_CNT_W-1:0] mon_cycles(input logic [1:0] sel);
        int ns;
        ns = `PDC_MON_SEL0_NS;
        case (sel)
            2'h1: ns = `PDC_MON_SEL1_NS;
            2'h2: ns = `PDC_MON_SEL2_NS;
            2'h3: ns = `PDC_MON_SEL3_NS;
            default: ns = `PDC_MON_SEL0_NS;
        endcase
        return `PDC_CNT_W'((ns * (`PDC_CLK_KHZ / 1000) + 999) / 1000);
    endfunction

    // Index: 0 error, 1 watchdog-disable, 2 enable, 3 address, 4 mon1, 5 mon2
    assign raw = {voltage_monitor_two_input, voltage_monitor_one_input, multi_pin_in,
                  enable_input, mcu_error_input, mcu_error_input};

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sync_a   <= 6'h03;
            sync_b   <= 6'h03;
            supply_a <= 1'b0;
            supply_b <= 1'b0;
        end
        else if (clock_enable)
        begin
            sync_a   <= raw;
            sync_b   <= sync_a;
            supply_a <= analog_supply_rail_valid;
            supply_b <= supply_a;
        end
    end

    // Startup: buffers come up only after supply valid and settings read
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= PDC_WAIT_SUPPLY;
        end
        else if (clock_enable)
        begin
            case (state)
                PDC_WAIT_SUPPLY:
                    if (supply_b)
                        state <= PDC_WAIT_OTP;
                PDC_WAIT_OTP:
                    if (!supply_b)
                        state <= PDC_WAIT_SUPPLY;
                    else if (otp_loaded)
                        state <= PDC_RUN;
                PDC_RUN:
                    if (!supply_b)
                        state <= PDC_WAIT_SUPPLY;
                default:
                    state <= PDC_WAIT_SUPPLY;
            endcase
        end
    end

    always_comb
    begin
        interval[0] = ERR_CYC;
        interval[1] = WDD_CYC;
        interval[2] = EN_CYC;
        interval[3] = ADR_CYC;
        interval[4] = mon_cycles(monitor_one_filter_select);
        interval[5] = mon_cycles(monitor_two_filter_select);
        filt_en     = {NUM_IN{state == PDC_RUN}};
        filt_en[0]  = (state == PDC_RUN) && !error_pin_alt_function;
        filt_en[1]  = (state == PDC_RUN) && error_pin_alt_function;
        filt_en[2]  = supply_b;
        filt_en[3]  = (state == PDC_RUN) && multi_pin_is_input;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_IN; g++)
        begin : gen_filt
            pdc_deglitch #(
                .RESET_LEVEL (`PDC_CNT_W'((g == 0) ? `PDC_ERR_RESET : `PDC_LEVEL_RESET))
            ) u_filt (
                .clock        (clock),
                .rst          (rst),
                .clock_enable (clock_enable),
                .enable       (filt_en[g]),
                .sample       (sync_b[g]),
                .interval     (interval[g]),
                .level        (filt[g])
            );
        end
    endgenerate

    // Registered copies so every output comes from a flip-flop
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            mcu_error_level        <= `PDC_ERR_RESET;
            watchdog_disable_input <= `PDC_LEVEL_RESET;
            enable_level           <= `PDC_LEVEL_RESET;
            address_select_level   <= `PDC_LEVEL_RESET;
            monitor_one_level      <= `PDC_LEVEL_RESET;
            monitor_two_level      <= `PDC_LEVEL_RESET;
            buffers_enabled        <= 1'b0;
            error_pin_pullup_on    <= 1'b1;
            enable_pulldown_on     <= 1'b1;
        end
        else if (clock_enable)
        begin
            mcu_error_level        <= filt[0];
            watchdog_disable_input <= filt[1];
            enable_level           <= filt[2];
            address_select_level   <= filt[3];
            monitor_one_level      <= filt[4];
            monitor_two_level      <= filt[5];
            buffers_enabled        <= (state == PDC_RUN);
            error_pin_pullup_on    <= 1'b1;
            enable_pulldown_on     <= 1'b1;
        end
    end

    function automatic pdc_pin_drive_type drive(input pdc_drive_cfg_type cfg,
                                                input logic asserted);
        pdc_pin_drive_type d;
        logic              high;
        high        = asserted ^ cfg.active_low;
        d.out       = high;
        d.oe        = cfg.open_drain ? !high : 1'b1;
        d.pullup_on = cfg.open_drain && cfg.pullup_enable && high;
        return d;
    endfunction

    // Before load, default open-drain active-low, deasserted
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reset_output_pin     <= '{out: 1'b1, oe: 1'b0, pullup_on: 1'b1};
            interrupt_output_pin <= '{out: 1'b1, oe: 1'b0, pullup_on: 1'b1};
        end
        else if (clock_enable)
        begin
            if (state != PDC_RUN)
            begin
                reset_output_pin     <= drive(DEFAULT_CFG, 1'b0);
                interrupt_output_pin <= drive(DEFAULT_CFG, 1'b0);
            end
            else if (multi_pin_is_input)
            begin
                reset_output_pin     <= drive(reset_cfg, reset_request);
                interrupt_output_pin <= '{out: 1'b0, oe: 1'b0, pullup_on: 1'b0};
            end
            else
            begin
                reset_output_pin     <= drive(reset_cfg, reset_request);
                interrupt_output_pin <= drive(interrupt_cfg,
                                              interrupt_request | general_output_value);
            end
        end
    end

endmodule
`default_nettype wire

// file: test/pdc_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_mcu_model
    import pdc_pkg::*;
(
    input  wire logic              fault,
    input  wire logic              ext_pull,
    input  wire pdc_pin_drive_type reset_pin,
    output logic                   mcu_error_input,
    output logic                   reset_wire
);
    // Fault is reported by pulling the error line low
    assign mcu_error_input = !fault;
    // Released pin settles to internal pull-up or board pull
    assign reset_wire = reset_pin.oe ? reset_pin.out : (reset_pin.pullup_on | ext_pull);
endmodule
`default_nettype wire

// file: test/pdc_pin_conditioning_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_pin_conditioning_checker
    import pdc_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              otp_loaded,
    input wire logic              multi_pin_is_input,
    input wire pdc_drive_cfg_type reset_cfg,
    input wire logic              reset_request,
    input wire logic              mcu_error_input,
    input wire logic              enable_input,
    input wire logic              error_pin_pullup_on,
    input wire logic              enable_pulldown_on,
    input wire logic              mcu_error_level,
    input wire logic              watchdog_disable_input,
    input wire logic              enable_level,
    input wire logic              buffers_enabled,
    input wire pdc_pin_drive_type reset_output_pin,
    input wire pdc_pin_drive_type interrupt_output_pin
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [13:0] en_cnt;
    logic [13:0] err_cnt;
    // Saturating stable-time counters seen from the pin side
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            en_cnt <= '0;
        else if ($changed(enable_input))
            en_cnt <= '0;
        else if (en_cnt != 14'h3FFF)
            en_cnt <= en_cnt + 14'h0001;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            err_cnt <= '0;
        else if ($changed(mcu_error_input))
            err_cnt <= '0;
        else if (err_cnt != 14'h3FFF)
            err_cnt <= err_cnt + 14'h0001;
    end
    a_pulls_on: assert property (error_pin_pullup_on && enable_pulldown_on)
        else $error("pull resistor off");
    a_buffers_after_load: assert property ($rose(buffers_enabled) |-> $past(otp_loaded, 2))
        else $error("buffers on before load");
    a_rst_pullup_low: assert property (!(reset_output_pin.oe && reset_output_pin.pullup_on))
        else $error("pull-up on while driven low");
    a_rst_od_polarity: assert property (buffers_enabled && $past(reset_cfg.open_drain)
        |-> reset_output_pin.oe == !($past(reset_request) ^ $past(reset_cfg.active_low)))
        else $error("reset pin level wrong");
    a_idle_default: assert property (!buffers_enabled |-> reset_output_pin == 3'h5)
        else $error("reset pin not idle");
    a_int_addr_mode: assert property (buffers_enabled && $past(multi_pin_is_input)
        |-> interrupt_output_pin == 3'h0)
        else $error("multi pin driven as input");
    a_en_deglitch: assert property ($changed(enable_level) |-> en_cnt >= 2000)
        else $error("enable changed early");
    a_err_deglitch: assert property ($changed(mcu_error_level) |-> err_cnt >= 3750)
        else $error("error level changed early");
    a_wdd_deglitch: assert property ($changed(watchdog_disable_input) |-> err_cnt >= 7500)
        else $error("watchdog disable changed early");
    c_enable: cover property ($rose(enable_level));
    c_wdd: cover property ($rose(watchdog_disable_input));
    c_run: cover property ($rose(buffers_enabled));
endmodule
bind pdc_pin_conditioning pdc_pin_conditioning_checker chk (.*);
`default_nettype wire

// file: test/tb_pdc_pin_conditioning.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pdc_pin_conditioning;
    import pdc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clock_enable, analog_supply_rail_valid, otp_loaded, error_pin_alt_function;
    logic multi_pin_is_input, reset_request, interrupt_request, general_output_value;
    logic mcu_error_input, enable_input, multi_pin_in, fault, ext_pull, reset_wire;
    logic voltage_monitor_one_input, voltage_monitor_two_input, buffers_enabled;
    logic error_pin_pullup_on, enable_pulldown_on, mcu_error_level, watchdog_disable_input;
    logic enable_level, address_select_level, monitor_one_level, monitor_two_level;
    logic [1:0] monitor_one_filter_select, monitor_two_filter_select;
    pdc_drive_cfg_type reset_cfg, interrupt_cfg;
    pdc_pin_drive_type reset_output_pin, interrupt_output_pin;
    logic [5:0] lv, lv_prev, cur;
    logic [5:0] exp_q[$];
    logic [31:0] seed = 32'h26F2;
    logic [31:0] r;
    int n_errors = 0;
    int check_count = 0;
    pdc_pin_conditioning DUT (.*);
    pdc_mcu_model mcu (.fault(fault), .ext_pull(ext_pull), .reset_pin(reset_output_pin),
        .mcu_error_input(mcu_error_input), .reset_wire(reset_wire));
    assign lv = {mcu_error_level, watchdog_disable_input, enable_level, address_select_level,
        monitor_one_level, monitor_two_level};
    always #2 clock = ~clock;
    task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic pdc_pin_drive_type pin_exp(pdc_drive_cfg_type c, logic req);
        logic hi;
        hi = req ^ c.active_low;
        return c.open_drain ? {hi, !hi, c.pullup_enable & hi} : {hi, 2'b10};
    endfunction
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Note the level vector expected once a filter settles
    task automatic note(input int idx, input logic v);
        cur[idx] = v;
        exp_q.push_back(cur);
    endtask
    always @(posedge clock)
    begin
        #1;
        if (!rst && lv !== lv_prev)
        begin
            if (exp_q.size() == 0)
                check("unexpected level", lv, lv_prev);
            else
                check("levels", lv, exp_q.pop_front());
        end
        lv_prev = lv;
    end
    initial
    begin
        {clock_enable, analog_supply_rail_valid, otp_loaded, error_pin_alt_function} = 4'h8;
        {multi_pin_is_input, reset_request, interrupt_request, general_output_value} = 4'h0;
        {enable_input, multi_pin_in, fault, ext_pull} = 4'h0;
        {voltage_monitor_one_input, voltage_monitor_two_input} = 2'h0;
        {monitor_one_filter_select, monitor_two_filter_select} = 4'h0;
        reset_cfg = 3'h0;
        interrupt_cfg = 3'h0;
        cur = 6'h20;
        hold(12);
        rst <= 1'b0;
        analog_supply_rail_valid <= 1'b1;
        reset_request <= 1'b1;
        // Monitor and enable pulses before load: neither may pass
        voltage_monitor_one_input <= 1'b1;
        enable_input <= 1'b1;
        hold(1500);
        check("idle pin", 6'(reset_output_pin), 6'h05);
        check("buffers off", 6'(buffers_enabled), 6'h00);
        voltage_monitor_one_input <= 1'b0;
        enable_input <= 1'b0;
        hold(10);
        enable_input <= 1'b1;
        note(3, 1'b1);
        // Frozen clock enable must stall the filter count
        hold(1000);
        clock_enable <= 1'b0;
        hold(1500);
        check("frozen level", 6'(enable_level), 6'h00);
        clock_enable <= 1'b1;
        hold(1100);
        otp_loaded <= 1'b1;
        for (int i = 0; i < 10 && buffers_enabled !== 1'b1; i++)
            hold(1);
        check("buffers on", 6'(buffers_enabled), 6'h01);
        fault <= 1'b1;
        hold(3000);
        fault <= 1'b0;
        hold(10);
        fault <= 1'b1;
        note(5, 1'b0);
        hold(3800);
        fault <= 1'b0;
        note(5, 1'b1);
        hold(3800);
        error_pin_alt_function <= 1'b1;
        note(4, 1'b1);
        hold(7600);
        fault <= 1'b1;
        hold(5000);
        fault <= 1'b0;
        hold(7600);
        fault <= 1'b1;
        note(4, 1'b0);
        hold(7600);
        fault <= 1'b0;
        error_pin_alt_function <= 1'b0;
        multi_pin_is_input <= 1'b1;
        multi_pin_in <= 1'b1;
        hold(1500);
        multi_pin_in <= 1'b0;
        hold(10);
        multi_pin_in <= 1'b1;
        note(2, 1'b1);
        hold(2100);
        for (int s = 0; s < 4; s++)
        begin
            monitor_one_filter_select <= 2'(s);
            monitor_two_filter_select <= 2'(3 - s);
            voltage_monitor_one_input <= ~voltage_monitor_one_input;
            voltage_monitor_two_input <= ~voltage_monitor_two_input;
            note(s < 2 ? 1 : 0, !cur[s < 2 ? 1 : 0]);
            note(s < 2 ? 0 : 1, !cur[s < 2 ? 0 : 1]);
            hold(8100);
        end
        for (int i = 0; i < 40; i++)
        begin
            r = xs();
            reset_cfg <= r[2:0];
            interrupt_cfg <= r[5:3];
            {reset_request, interrupt_request, general_output_value} <= r[8:6];
            multi_pin_is_input <= r[9];
            hold(2);
            #1;
            check("reset pin", 6'(reset_output_pin), 6'(pin_exp(reset_cfg, reset_request)));
            check("int pin", 6'(interrupt_output_pin), multi_pin_is_input ? 6'h00
                : 6'(pin_exp(interrupt_cfg, interrupt_request | general_output_value)));
            if (!reset_cfg.open_drain || reset_cfg.pullup_enable)
                check("reset wire", 6'(reset_wire), 6'(reset_request ^ reset_cfg.active_low));
            hold(1);
        end
        hold(10);
        check("pending notes", 6'(exp_q.size()), 6'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
